/* File: hw/dwx_consts.vh */
// Constants for the double-word arithmetic, shift and exclusive-OR execution block.
`ifndef DWX_CONSTS_VH
`define DWX_CONSTS_VH
`define DWX_OP_PERMIT   4'h5
`define DWX_OP_XOR      4'h6
`define DWX_OP_SHIFT    4'h7
`define DWX_OP_DADD     4'hA
`define DWX_OP_DSUB     4'hB
`define DWX_OP_SWAP     4'hC
`define DWX_SYS_REG     4'hF
`define DWX_SH_LA       3'h0
`define DWX_SH_RA       3'h1
`define DWX_SH_LL       3'h2
`define DWX_SH_RL       3'h3
`define DWX_SH_LN       3'h4
`define DWX_SH_RN       3'h5
`define DWX_SH_LC       3'h6
`define DWX_SH_RC       3'h7
`define DWX_MODE_REG    2'h0
`define DWX_MODE_REGIND 2'h1
`define DWX_MODE_IND    2'h3
`define DWX_NORM_MAX    5'h1F
`define DWX_ST_IDLE     3'h0
`define DWX_ST_PTR      3'h1
`define DWX_ST_RD1      3'h2
`define DWX_ST_RD2      3'h3
`define DWX_ST_MWR      3'h4
`define DWX_ST_NORM     3'h5
`endif

/* File: hw/dwx_addsub32.v */
// 32-bit adder and subtractor for the accumulator pair.
`timescale 1ns/1ps
module dwx_addsub32 #(
	parameter W = 32
) (
	input  wire [W-1:0] a_in,
	input  wire [W-1:0] b_in,
	input  wire         sub_in,
	output wire [W-1:0] sum_out
);
	// Carries out of the top bit are dropped; no condition register is kept here.
	assign sum_out = sub_in ? (a_in - b_in) : (a_in + b_in);
endmodule // dwx_addsub32

/* File: hw/dwx_shift32.v */
// Double-length barrel shifter with arithmetic, logical and circular variants.
`timescale 1ns/1ps
module dwx_shift32 (
	input  wire [31:0] value_in,
	input  wire [2:0]  sel_in,
	input  wire [4:0]  count_in,
	output reg  [31:0] result_out
);
	`include "dwx_consts.vh"
	wire [5:0]  amt = {1'b0, count_in};
	wire [5:0]  inv = 6'h20 - amt;
	wire [31:0] lsh = value_in << amt;
	wire [31:0] rsh = value_in >> amt;
	wire [31:0] ash = $signed(value_in) >>> amt;
	wire [31:0] rol = lsh | (value_in >> inv);
	wire [31:0] ror = rsh | (value_in << inv);
	always @*
	begin
		case (sel_in)
			`DWX_SH_LA, `DWX_SH_LN: result_out = {value_in[31], lsh[30:0]};
			`DWX_SH_LL: result_out = lsh;
			`DWX_SH_LC: result_out = rol;
			`DWX_SH_RA, `DWX_SH_RN: result_out = ash;
			`DWX_SH_RL: result_out = rsh;
			default: result_out = ror;
		endcase
	end
endmodule // dwx_shift32

/* File: hw/dwx_exec.v */
// Execution unit for double add/subtract, double shifts, exclusive OR and char exchange.
// Overview of operation
// - Opcode 1010 with a register operand adds the pair R2,R2+1 into the accumulator pair.
// - The double add with constant adds the long immediate into the accumulator pair.
// - Indexed double subtract takes the two words at base plus R2 off the accumulator pair.
// - Indirect double subtract reads a pointer first, then subtracts the two words it names.
// - Register double subtract takes R2,R2+1 off the accumulator pair.
// - The double subtract with constant takes the long immediate off the accumulator pair.
// - Shift selector 000, 110 and 010 give left arithmetic, circular and logical shifts.
// - Shift selector 001, 111 and 011 give right arithmetic, circular and logical shifts.
// - Opcode 0101 sets the status so that interrupts are accepted from then on.
// - Opcode 1100 puts R2's left character in R1's right half and R2's right in R1's left.
// - Indexed exclusive OR with destination clear writes R1 xor memory word into R1.
// - Indexed exclusive OR with destination set writes the result back to that memory word.
// - Indexed-indirect exclusive OR with destination set fetches a pointer and stores there.
// - An instruction whose R1 field is 1111 runs only in system mode.
`timescale 1ns/1ps
module dwx_exec (
	input  wire        core_clk_in,
	input  wire        resetn_in,
	input  wire        start_in,
	input  wire [3:0]  opcode_in,
	input  wire        format_in,
	input  wire [1:0]  mode_in,
	input  wire        dest_in,
	input  wire [3:0]  first_reg_field_in,
	input  wire [3:0]  second_reg_field_in,
	input  wire [2:0]  shift_sel_in,
	input  wire [4:0]  shift_cnt_in,
	input  wire [14:0] addr_in,
	input  wire [31:0] long_immediate_in,
	input  wire        sys_mode_in,
	input  wire        mem_ack_in,
	input  wire [15:0] mem_rdata_in,
	input  wire        rf_we_in,
	input  wire [3:0]  rf_waddr_in,
	input  wire [15:0] rf_wdata_in,
	input  wire [3:0]  rf_raddr_in,
	output wire        busy_out,
	output wire        done_out,
	output wire        trap_out,
	output wire        irq_permit_out,
	output wire        mem_req_out,
	output wire        mem_we_out,
	output wire [14:0] mem_addr_out,
	output wire [15:0] mem_wdata_out,
	output wire [15:0] rf_rdata_out
);
	`include "dwx_consts.vh"
	reg  [15:0] rf [0:15];
	reg  [2:0]  st_r;
	reg  [3:0]  opc_r;
	reg  [3:0]  r1_r;
	reg  [3:0]  r2_r;
	reg  [2:0]  sel_r;
	reg         dst_r;
	reg  [4:0]  norm_cnt_r;
	reg  [15:0] op_hi_r;
	reg         busy_r;
	reg         done_r;
	reg         trap_r;
	reg         permit_r;
	reg         mem_req_r;
	reg         mem_we_r;
	reg  [14:0] mem_addr_r;
	reg  [15:0] mem_wdata_r;
	reg  [15:0] rd_data_r;
	reg         wa_en;
	reg  [3:0]  wa_addr;
	reg  [15:0] wa_data;
	reg         wb_en;
	reg  [15:0] wb_data;
	wire        idle = (st_r == `DWX_ST_IDLE);
	wire        go = idle & start_in;
	wire [3:0]  ar1 = idle ? first_reg_field_in : r1_r;
	wire [3:0]  ar2 = idle ? second_reg_field_in : r2_r;
	wire [3:0]  ar1p = ar1 + 4'h1;
	wire [3:0]  ar2p = ar2 + 4'h1;
	wire [31:0] acc = {rf[ar1], rf[ar1p]};
	wire [3:0]  opc = idle ? opcode_in : opc_r;
	wire [2:0]  sel = idle ? shift_sel_in : sel_r;
	wire        priv_bad = (first_reg_field_in == `DWX_SYS_REG) & ~sys_mode_in;
	wire        ok = go & ~priv_bad;
	wire        is_dbl = (opc == `DWX_OP_DADD) | (opc == `DWX_OP_DSUB);
	wire        is_norm = (sel == `DWX_SH_LN) | (sel == `DWX_SH_RN);
	wire [14:0] idx = (second_reg_field_in != 4'h0) ? rf[second_reg_field_in][14:0] : 15'h0000;
	wire [14:0] ea = addr_in + idx;
	wire        rd2_phase = (st_r == `DWX_ST_RD2);
	wire [31:0] opnd = rd2_phase ? {op_hi_r, mem_rdata_in} :
		((mode_in == `DWX_MODE_REG) ? {rf[ar2], rf[ar2p]} : long_immediate_in);
	wire [31:0] sum;
	wire [31:0] shres;
	wire [15:0] xres = rf[ar1] ^ mem_rdata_in;
	wire        ack = mem_req_r & mem_ack_in;
	wire        imm_dbl = ok & is_dbl & format_in & (mode_in != `DWX_MODE_REGIND);
	wire        sh_now = ok & (opc == `DWX_OP_SHIFT) & ~is_norm;
	wire        rd2_done = rd2_phase & ack;
	wire        rd1_x = (st_r == `DWX_ST_RD1) & ack & (opc_r == `DWX_OP_XOR);
	wire        norm_st = (st_r == `DWX_ST_NORM);
	wire        acc_flat = (acc == 32'h00000000) | (acc == 32'hFFFFFFFF);
	wire        cnt_full = (norm_cnt_r == `DWX_NORM_MAX);
	// A zero or all-ones pair never normalizes, so it stops at once with a count of zero.
	wire        norm_stop = acc_flat | cnt_full |
		(sel_r[0] ? acc[0] : (acc[31] != acc[30]));

	dwx_addsub32 #(
		.W      (32)
	) u_addsub (
		.a_in   (acc),
		.b_in   (opnd),
		.sub_in (opc == `DWX_OP_DSUB),
		.sum_out(sum)
	);

	dwx_shift32 u_shift (
		.value_in  (acc),
		.sel_in    (sel),
		.count_in  (idle ? shift_cnt_in : 5'h01),
		.result_out(shres)
	);

	always @*
	begin
		wa_en = 1'b0;
		wa_addr = ar1;
		wa_data = 16'h0000;
		wb_en = 1'b0;
		wb_data = 16'h0000;
		if (imm_dbl | rd2_done)
		begin
			// Both halves land in the same edge so the pair is never seen half-updated.
			wa_en = 1'b1;
			wb_en = 1'b1;
			wa_data = sum[31:16];
			wb_data = sum[15:0];
		end
		else if (sh_now | (norm_st & ~norm_stop))
		begin
			wa_en = 1'b1;
			wb_en = 1'b1;
			wa_data = shres[31:16];
			wb_data = shres[15:0];
		end
		else if (norm_st)
		begin
			wa_en = 1'b1;
			wa_addr = r2_r;
			wa_data = {11'h000, norm_cnt_r};
		end
		else if (ok & (opc == `DWX_OP_SWAP))
		begin
			wa_en = 1'b1;
			wa_data = {rf[ar2][7:0], rf[ar2][15:8]};
		end
		else if (rd1_x & ~dst_r)
		begin
			wa_en = 1'b1;
			wa_data = xres;
		end
		else if (idle & ~start_in & rf_we_in)
		begin
			wa_en = 1'b1;
			wa_addr = rf_waddr_in;
			wa_data = rf_wdata_in;
		end
	end

	// Register contents are data, not control, so they carry no reset.
	always @(posedge core_clk_in)
	begin
		if (wa_en)
			rf[wa_addr] <= wa_data;
		if (wb_en)
			rf[ar1p] <= wb_data;
	end

	always @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			st_r <= `DWX_ST_IDLE;
			opc_r <= 4'h0;
			r1_r <= 4'h0;
			r2_r <= 4'h0;
			sel_r <= 3'h0;
			dst_r <= 1'b0;
			norm_cnt_r <= 5'h00;
			op_hi_r <= 16'h0000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			trap_r <= 1'b0;
			permit_r <= 1'b0;
			mem_req_r <= 1'b0;
			mem_we_r <= 1'b0;
			mem_addr_r <= 15'h0000;
			mem_wdata_r <= 16'h0000;
			rd_data_r <= 16'h0000;
		end
		else
		begin
			done_r <= 1'b0;
			trap_r <= 1'b0;
			rd_data_r <= rf[rf_raddr_in];
			case (st_r)
				`DWX_ST_IDLE:
				begin
					if (go)
					begin
						opc_r <= opcode_in;
						r1_r <= first_reg_field_in;
						r2_r <= second_reg_field_in;
						sel_r <= shift_sel_in;
						dst_r <= dest_in;
						norm_cnt_r <= 5'h00;
						if (priv_bad)
							trap_r <= 1'b1;
						else if (opcode_in == `DWX_OP_PERMIT)
						begin
							permit_r <= 1'b1;
							done_r <= 1'b1;
						end
						else if ((opcode_in == `DWX_OP_SHIFT) & is_norm)
						begin
							st_r <= `DWX_ST_NORM;
							busy_r <= 1'b1;
						end
						else if (is_dbl & format_in & (mode_in == `DWX_MODE_REGIND))
						begin
							mem_req_r <= 1'b1;
							mem_addr_r <= rf[second_reg_field_in][14:0];
							st_r <= `DWX_ST_RD1;
							busy_r <= 1'b1;
						end
						else if ((is_dbl | (opcode_in == `DWX_OP_XOR)) & ~format_in)
						begin
							mem_req_r <= 1'b1;
							mem_addr_r <= ea;
							st_r <= (mode_in == `DWX_MODE_IND) ? `DWX_ST_PTR : `DWX_ST_RD1;
							busy_r <= 1'b1;
						end
						else
							done_r <= 1'b1;
					end
				end
				`DWX_ST_PTR:
				begin
					if (ack)
					begin
						mem_addr_r <= mem_rdata_in[14:0];
						st_r <= `DWX_ST_RD1;
					end
				end
				`DWX_ST_RD1:
				begin
					if (ack)
					begin
						if (opc_r == `DWX_OP_XOR)
						begin
							if (dst_r)
							begin
								mem_we_r <= 1'b1;
								mem_wdata_r <= xres;
								st_r <= `DWX_ST_MWR;
							end
							else
							begin
								mem_req_r <= 1'b0;
								done_r <= 1'b1;
								busy_r <= 1'b0;
								st_r <= `DWX_ST_IDLE;
							end
						end
						else
						begin
							op_hi_r <= mem_rdata_in;
							mem_addr_r <= mem_addr_r + 15'h0001;
							st_r <= `DWX_ST_RD2;
						end
					end
				end
				`DWX_ST_RD2, `DWX_ST_MWR:
				begin
					if (ack)
					begin
						mem_req_r <= 1'b0;
						mem_we_r <= 1'b0;
						done_r <= 1'b1;
						busy_r <= 1'b0;
						st_r <= `DWX_ST_IDLE;
					end
				end
				`DWX_ST_NORM:
				begin
					if (norm_stop)
					begin
						done_r <= 1'b1;
						busy_r <= 1'b0;
						st_r <= `DWX_ST_IDLE;
					end
					else
						norm_cnt_r <= norm_cnt_r + 5'h01;
				end
				default:
				begin
					busy_r <= 1'b0;
					mem_req_r <= 1'b0;
					mem_we_r <= 1'b0;
					st_r <= `DWX_ST_IDLE;
				end
			endcase
		end
	end

	assign busy_out = busy_r;
	assign done_out = done_r;
	assign trap_out = trap_r;
	assign irq_permit_out = permit_r;
	assign mem_req_out = mem_req_r;
	assign mem_we_out = mem_we_r;
	assign mem_addr_out = mem_addr_r;
	assign mem_wdata_out = mem_wdata_r;
	assign rf_rdata_out = rd_data_r;
endmodule // dwx_exec

/* File: tb/dwx_exec_asserts.sv */
// Port checker for the double-word execution unit.
`timescale 1ns/1ps
module dwx_exec_asserts (
	input wire        core_clk_in,
	input wire        resetn_in,
	input wire        start_in,
	input wire [3:0]  opcode_in,
	input wire        format_in,
	input wire [1:0]  mode_in,
	input wire [3:0]  first_reg_field_in,
	input wire [3:0]  second_reg_field_in,
	input wire [14:0] addr_in,
	input wire        sys_mode_in,
	input wire        mem_ack_in,
	input wire        busy_out,
	input wire        done_out,
	input wire        trap_out,
	input wire        irq_permit_out,
	input wire        mem_req_out,
	input wire [14:0] mem_addr_out
);
	wire tk = start_in && !busy_out;
	wire ok = tk && (first_reg_field_in != 4'hF || sys_mode_in);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	AST_TRAP: assert property (tk && !ok |=> trap_out && !done_out)
		else $error("trap missing");
	AST_TRAP_ALONE: assert property (trap_out |-> !done_out && !busy_out)
		else $error("trap with activity");
	AST_PERMIT: assert property (ok && opcode_in == 4'h5 |=> irq_permit_out)
		else $error("permit not set");
	AST_PERMIT_KEEP: assert property (irq_permit_out |=> irq_permit_out)
		else $error("permit lost");
	AST_IMM: assert property (ok && format_in && mode_in != 2'h1 &&
		opcode_in[3:1] == 3'h5 |=> done_out && !busy_out) else $error("no immediate done");
	AST_DIRECT_ADDR: assert property (ok && !format_in && mode_in == 2'h2 &&
		second_reg_field_in == 4'h0 && (opcode_in == 4'h6 || opcode_in == 4'hB)
		|=> mem_req_out && mem_addr_out == $past(addr_in)) else $error("bad address");
	AST_HOLD: assert property (mem_req_out && !mem_ack_in |=> mem_req_out &&
		$stable(mem_addr_out)) else $error("request dropped");
	AST_REQ_BUSY: assert property (mem_req_out |-> busy_out)
		else $error("request while idle");
	AST_END: assert property ($rose(busy_out) |-> ##[1:60] $fell(busy_out))
		else $error("busy too long");
	cover property (trap_out);
	cover property (mem_req_out && mem_ack_in);
	cover property ($rose(irq_permit_out));
endmodule // dwx_exec_asserts
bind dwx_exec dwx_exec_asserts u_chk (
	.core_clk_in        (core_clk_in),
	.resetn_in          (resetn_in),
	.start_in           (start_in),
	.opcode_in          (opcode_in),
	.format_in          (format_in),
	.mode_in            (mode_in),
	.first_reg_field_in (first_reg_field_in),
	.second_reg_field_in(second_reg_field_in),
	.addr_in            (addr_in),
	.sys_mode_in        (sys_mode_in),
	.mem_ack_in         (mem_ack_in),
	.busy_out           (busy_out),
	.done_out           (done_out),
	.trap_out           (trap_out),
	.irq_permit_out     (irq_permit_out),
	.mem_req_out        (mem_req_out),
	.mem_addr_out       (mem_addr_out)
);

/* File: tb/dwx_mem_model.sv */
// Word memory model on the far side of the execution unit.
`timescale 1ns/1ps
module dwx_mem_model (
	input  wire        clk_in,
	input  wire        rstn_in,
	input  wire        req_in,
	input  wire        we_in,
	input  wire [14:0] addr_in,
	input  wire [15:0] wdata_in,
	input  wire [1:0]  lat_in,
	output reg         ack_out,
	output wire [15:0] rdata_out
);
	reg [15:0] m [0:63];
	reg [15:0] rd_r;
	reg [1:0]  cnt_r;
	// Only 64 words are kept, so higher addresses alias; the bench stays low.
	assign rdata_out = ack_out ? rd_r : ~rd_r;
	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			ack_out <= 1'b0;
			cnt_r   <= 2'h0;
			rd_r    <= 16'h0000;
		end
		else
		begin
			ack_out <= 1'b0;
			if (req_in && !ack_out)
			begin
				if (cnt_r >= lat_in)
				begin
					ack_out <= 1'b1;
					cnt_r   <= 2'h0;
					if (we_in)
						m[addr_in[5:0]] <= wdata_in;
					else
						rd_r <= m[addr_in[5:0]];
				end
				else
					cnt_r <= cnt_r + 2'h1;
			end
		end
	end
endmodule // dwx_mem_model

/* File: tb/test_dwx_exec.sv */
// Self-checking bench for the double-word execution unit.
`timescale 1ns/1ps
module test_dwx_exec;
	reg         clk = 0, rstn = 0, start = 0, fmt = 0, dest = 0, sys = 0, rwe = 0, tr;
	reg  [3:0]  op = 0, r1 = 4'h4, r2 = 4'h6, wa = 0, ra = 0;
	reg  [1:0]  md = 0, lat = 0;
	reg  [2:0]  sel = 0;
	reg  [4:0]  sc = 5'h04;
	reg  [14:0] adr = 0;
	reg  [15:0] wd = 0;
	reg  [31:0] v;
	reg  [41:0] rows [0:9];
	wire        busy, done, trap, irqp, req, we, ack;
	wire [14:0] madr;
	wire [15:0] mwd, mrd, rfd;
	int         error_cnt = 0, n_compared = 0, i;
	dwx_exec uut (.core_clk_in(clk), .resetn_in(rstn), .start_in(start), .opcode_in(op),
		.format_in(fmt), .mode_in(md), .dest_in(dest), .first_reg_field_in(r1),
		.second_reg_field_in(r2), .shift_sel_in(sel), .shift_cnt_in(sc), .addr_in(adr),
		.long_immediate_in(32'h1000_0001), .sys_mode_in(sys), .mem_ack_in(ack),
		.mem_rdata_in(mrd), .rf_we_in(rwe), .rf_waddr_in(wa), .rf_wdata_in(wd),
		.rf_raddr_in(ra), .busy_out(busy), .done_out(done), .trap_out(trap),
		.irq_permit_out(irqp), .mem_req_out(req), .mem_we_out(we), .mem_addr_out(madr),
		.mem_wdata_out(mwd), .rf_rdata_out(rfd));
	dwx_mem_model mem (.clk_in(clk), .rstn_in(rstn), .req_in(req), .we_in(we),
		.addr_in(madr), .wdata_in(mwd), .lat_in(lat), .ack_out(ack), .rdata_out(mrd));
	initial forever #5 clk = ~clk;
	task chk(input [31:0] g, input [31:0] e);
		n_compared++;
		if (g !== e)
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		if (g !== e)
			error_cnt++;
	endtask
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// The write strobe is left high between writes; go and rdp lower it.
	task wr(input [3:0] a, input [15:0] d);
		wa = a;
		wd = d;
		rwe = 1;
		@(posedge clk) #1;
	endtask
	task st;
		wr(4'h4, 16'h8123);
		wr(4'h5, 16'h4567);
		wr(4'h6, 16'h0001);
		wr(4'h7, 16'hF00F);
	endtask
	task go;
		rwe = 0;
		start = 1;
		@(posedge clk) #1 start = 0;
		for (i = 0; done !== 1'b1 && trap !== 1'b1; i++)
		begin
			if (i == 100)
				chk(0, 1);
			if (i == 100)
				final_report;
			@(posedge clk) #1;
		end
		tr = trap;
		@(posedge clk) #1;
	endtask
	task rdp(input [3:0] a);
		rwe = 0;
		ra = a;
		@(posedge clk) #1 v[31:16] = rfd;
		ra = a + 4'h1;
		@(posedge clk) #1 v[15:0] = rfd;
	endtask
	initial
	begin
		rows = '{{4'hA, 1'b1, 2'h0, 3'h0, 32'h8125_3576}, {4'hA, 1'b1, 2'h2, 3'h0, 32'h9123_4568},
			{4'hB, 1'b1, 2'h0, 3'h0, 32'h8121_5558}, {4'hB, 1'b1, 2'h2, 3'h0, 32'h7123_4566},
			{4'h7, 1'b0, 2'h0, 3'h0, 32'h9234_5670}, {4'h7, 1'b0, 2'h0, 3'h6, 32'h1234_5678},
			{4'h7, 1'b0, 2'h0, 3'h2, 32'h1234_5670}, {4'h7, 1'b0, 2'h0, 3'h1, 32'hF812_3456},
			{4'h7, 1'b0, 2'h0, 3'h7, 32'h7812_3456}, {4'h7, 1'b0, 2'h0, 3'h3, 32'h0812_3456}};
		repeat (10) @(posedge clk);
		#1 chk({busy, done, trap, irqp, req}, 0);
		rstn = 1;
		for (int k = 0; k < 10; k++)
		begin
			st;
			{op, fmt, md, sel} = rows[k][41:32];
			go;
			rdp(r1);
			chk(v, rows[k][31:0]);
		end
		st;
		{sel, sc} = {3'h6, 5'h00};
		go;
		rdp(r1);
		chk(v, 32'h8123_4567);
		st;
		{sel, sc} = {3'h7, 5'h1F};
		go;
		rdp(r1);
		chk(v, 32'h0246_8ACF);
		$display("table done");
		st;
		wr(4'hF, 16'h5555);
		{op, fmt, md, r1} = {4'hC, 1'b1, 2'h0, 4'hF};
		go;
		chk(tr, 1);
		rdp(4'hF);
		chk(v[31:16], 16'h5555);
		sys = 1;
		go;
		rdp(4'hF);
		chk(v[31:16], 16'h0100);
		{op, fmt, r1} = {4'h5, 1'b0, 4'h4};
		go;
		chk(irqp, 1);
		$display("swap, privilege and permit done");
		st;
		{mem.m[17], mem.m[18], lat, adr} = {32'h0012_3456, 2'h2, 15'h0010};
		{op, md} = {4'hB, 2'h2};
		go;
		rdp(4'h4);
		chk(v, 32'h8111_1111);
		st;
		{mem.m[32], mem.m[48], mem.m[49]} = {16'h0030, 32'h0001_0001};
		{lat, adr, md, r2} = {2'h0, 15'h0020, 2'h3, 4'h0};
		go;
		rdp(4'h4);
		chk(v, 32'h8122_4566);
		st;
		{op, md, r2, adr} = {4'h6, 2'h2, 4'h6, 15'h0010};
		go;
		rdp(4'h4);
		chk(v[31:16], 16'h8131);
		st;
		{dest, r2, adr} = {1'b1, 4'h0, 15'h0011};
		go;
		chk(mem.m[17], 16'h8131);
		st;
		{mem.m[17], mem.m[40], md, r2, adr} = {32'h0028_00FF, 2'h3, 4'h6, 15'h0010};
		go;
		chk(mem.m[40], 16'h81DC);
		$display("memory tests done");
		st;
		wr(4'h4, 16'h00F0);
		wr(4'h5, 16'h0000);
		{op, sel} = {4'h7, 3'h4};
		go;
		rdp(4'h4);
		chk(v, 32'h7800_0000);
		rdp(4'h6);
		chk(v[31:16], 16'h0007);
		rstn = 0;
		@(posedge clk) #1;
		chk(irqp, 0);
		chk({busy, done, trap, irqp, req}, 0);
		rstn = 1;
		st;
		{op, fmt, md, r1} = {4'hA, 1'b1, 2'h0, 4'h4};
		go;
		rdp(4'h4);
		chk(v, 32'h8125_3576);
		$display("normalize and reset done");
		final_report;
	end
endmodule // test_dwx_exec
